// File: hdl/nsbhp_map.vh
// constants for the narrow system bus handshake port
// Overview of operation
// - shared address/data path is 32 bits, bidirectional, address and data in different cycles.
// - 5-bit bidirectional command/identifier bus, driven by whichever side sources the transfer.
// - unused upper command, check and parity pins are always driven low.
// - processor valid output asserted exactly when it drives valid word and command.
// - mastership output asserted while processor owns bus, deasserted when agent owns it.
// - handshake signals marked active low are active low on both sides.
// - top command bit low marks address cycle, high marks data cycle.
// - no further request while a processor read still awaits final response data, unless an agent bus request in ST_TURN moved the read to ST_SLAVE.
// - timeout counter raises bus error when a read reply does not arrive in time, unless an agent bus request in ST_TURN moved the read to ST_SLAVE.
// - outputs launched from registers and inputs captured into registers on rising edge.
`ifndef NSBHP_MAP_VH
`define NSBHP_MAP_VH
`define NSBHP_AD_W 32
`define NSBHP_CMD_W 5
`define NSBHP_CMD_KIND_BIT 4
`define NSBHP_CMD_FINAL_BIT 3
`define NSBHP_CMD_ERROR_BIT 2
`define NSBHP_TIMEOUT_NS 40960
`define NSBHP_CLK_NS 10
// read timeout in clock cycles, 40960 ns at 10 ns per cycle
`define NSBHP_TIMEOUT_CYC 16'h1000
`define NSBHP_TMR_W 16
`endif

// File: hdl/nsbhp_timeout.v
// read reply watchdog counter
`timescale 1ns/100ps
`include "nsbhp_map.vh"
module nsbhp_timeout #(
  parameter [`NSBHP_TMR_W-1:0] LIMIT = `NSBHP_TIMEOUT_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire run,
  input wire restart,
  // status
  output reg expired
);
  reg [`NSBHP_TMR_W-1:0] count_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {`NSBHP_TMR_W{1'b0}};
      expired <= 1'b0;
    end else if (!run || restart) begin
      count_reg <= {`NSBHP_TMR_W{1'b0}};
      expired <= 1'b0;
    end else if (count_reg == LIMIT - 16'h0001) begin
      expired <= 1'b1;
    end else begin
      count_reg <= count_reg + 16'h0001;
      expired <= 1'b0;
    end
  end
endmodule // nsbhp_timeout

// File: hdl/nsbhp_port.v
// processor end of the narrow system bus handshake
`timescale 1ns/100ps
`include "nsbhp_map.vh"
module nsbhp_port #(
  parameter [`NSBHP_TMR_W-1:0] TIMEOUT_CYC = `NSBHP_TIMEOUT_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // shared address/data bus
  input wire [`NSBHP_AD_W-1:0] addr_data_bus_in,
  output reg [`NSBHP_AD_W-1:0] addr_data_bus_out,
  output reg addr_data_bus_oe,
  // command/identifier bus
  input wire [`NSBHP_CMD_W-1:0] command_id_bus_in,
  output reg [`NSBHP_CMD_W-1:0] command_id_bus_out,
  output reg command_id_bus_oe,
  // tied-off pins
  output wire [3:0] command_id_upper_out,
  output wire [3:0] unused_check_bits,
  output wire unused_command_parity,
  // handshake
  input wire agent_valid_n,
  output reg cpu_valid_n,
  input wire agent_ownership_request_n,
  output reg cpu_owns_bus_n,
  input wire agent_accept_ready_n,
  input wire unused_read_ready_n,
  // core request side
  input wire req_valid,
  input wire req_is_read,
  input wire [`NSBHP_AD_W-1:0] req_addr,
  input wire [3:0] req_cmd,
  input wire [`NSBHP_AD_W-1:0] req_wdata,
  input wire [3:0] req_wid,
  output wire req_ready,
  // core response side
  output reg rsp_valid,
  output reg [`NSBHP_AD_W-1:0] rsp_data,
  output reg [3:0] rsp_id,
  output reg ext_addr_valid,
  output reg bus_error
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_WDATA = 3'd1;
  localparam [2:0] ST_TURN = 3'd2;
  localparam [2:0] ST_WAIT = 3'd3;
  localparam [2:0] ST_SLAVE = 3'd4;
  reg [2:0] state_reg, state_next;
  reg [`NSBHP_AD_W-1:0] wdata_reg;
  reg [3:0] wid_reg;
  reg [`NSBHP_AD_W-1:0] ad_in_reg;
  reg [`NSBHP_CMD_W-1:0] cmd_in_reg;
  reg evalid_reg, agent_ownership_request_n_reg, eok_reg;
  wire expired;
  wire agent_word = evalid_reg;
  wire agent_data = agent_word && cmd_in_reg[`NSBHP_CMD_KIND_BIT];
  wire final_word = agent_data && !cmd_in_reg[`NSBHP_CMD_FINAL_BIT];
  assign command_id_upper_out = 4'h0;
  assign unused_check_bits = 4'h0;
  assign unused_command_parity = 1'b0;
  // gated by ready, only from idle
  assign req_ready = (state_reg == ST_IDLE) && eok_reg && !agent_ownership_request_n_reg;
  wire start = req_valid && req_ready;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_in_reg <= 32'h00000000;
      cmd_in_reg <= 5'h00;
      evalid_reg <= 1'b0;
      agent_ownership_request_n_reg <= 1'b0;
      eok_reg <= 1'b0;
    end else begin
      ad_in_reg <= addr_data_bus_in;
      cmd_in_reg <= command_id_bus_in;
      evalid_reg <= !agent_valid_n;
      agent_ownership_request_n_reg <= !agent_ownership_request_n;
      eok_reg <= !agent_accept_ready_n;
    end
  end
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start && req_is_read)
          state_next = ST_TURN;
        else if (start)
          state_next = ST_WDATA;
        else if (agent_ownership_request_n_reg)
          state_next = ST_TURN;
      end
      ST_WDATA: state_next = ST_IDLE;
      // one idle cycle so drivers never overlap
      ST_TURN: state_next = agent_ownership_request_n_reg ? ST_SLAVE : ST_WAIT;
      ST_WAIT: begin
        if (final_word || expired)
          state_next = ST_IDLE;
      end
      ST_SLAVE: begin
        if (!agent_ownership_request_n_reg && !agent_word)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      wdata_reg <= 32'h00000000;
      wid_reg <= 4'h0;
      addr_data_bus_out <= 32'h00000000;
      command_id_bus_out <= 5'h00;
      addr_data_bus_oe <= 1'b1;
      command_id_bus_oe <= 1'b1;
      cpu_valid_n <= 1'b1;
      cpu_owns_bus_n <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 32'h00000000;
      rsp_id <= 4'h0;
      ext_addr_valid <= 1'b0;
      bus_error <= 1'b0;
    end else begin
      state_reg <= state_next;
      cpu_valid_n <= 1'b1;
      if (start) begin
        wdata_reg <= req_wdata;
        wid_reg <= req_wid;
      end
      // address then data, valid only with a word
      if (start) begin
        addr_data_bus_out <= req_addr;
        command_id_bus_out <= {1'b0, req_cmd};
        cpu_valid_n <= 1'b0;
      end else if (state_reg == ST_WDATA) begin
        addr_data_bus_out <= wdata_reg;
        command_id_bus_out <= {1'b1, wid_reg};
        cpu_valid_n <= 1'b0;
      end
      // drive only while owner
      // read address cycle is still driven, release follows it
      addr_data_bus_oe <= start || (state_next == ST_IDLE) || (state_next == ST_WDATA);
      command_id_bus_oe <= start || (state_next == ST_IDLE) || (state_next == ST_WDATA);
      cpu_owns_bus_n <= !(start || (state_next == ST_IDLE) || (state_next == ST_WDATA));
      rsp_valid <= agent_data && (state_reg == ST_WAIT || state_reg == ST_SLAVE);
      ext_addr_valid <= agent_word && !cmd_in_reg[`NSBHP_CMD_KIND_BIT] && state_reg == ST_SLAVE;
      if (agent_word) begin
        rsp_data <= ad_in_reg;
        rsp_id <= cmd_in_reg[3:0];
      end
      // error on timeout or error identifier
      bus_error <= (state_reg == ST_WAIT) && (expired || (agent_data && cmd_in_reg[`NSBHP_CMD_ERROR_BIT]));
    end
  end
  nsbhp_timeout #(
    .LIMIT(TIMEOUT_CYC)
  ) u_timeout (
    .clk(clk),
    .rst_n(rst_n),
    .run(state_reg == ST_WAIT),
    .restart(agent_data),
    .expired(expired)
  );
endmodule // nsbhp_port

// File: bench/nsbhp_assertions.sv
// checker on the port pins
`timescale 1ns/100ps
`include "nsbhp_map.vh"
module nsbhp_assertions (
  // clock and reset
  input wire clk, rst_n,
  // pins
  input wire [`NSBHP_AD_W-1:0] addr_data_bus_out, input wire addr_data_bus_oe, command_id_bus_oe,
  input wire [`NSBHP_CMD_W-1:0] command_id_bus_out, input wire [3:0] command_id_upper_out, unused_check_bits,
  input wire unused_command_parity, cpu_valid_n, cpu_owns_bus_n, agent_accept_ready_n, agent_ownership_request_n,
  // core side
  input wire req_valid, req_is_read, req_ready, input wire [`NSBHP_AD_W-1:0] req_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  tied_low_a: assert property (!{command_id_upper_out, unused_check_bits, unused_command_parity})
    else $error("tie-off high");
  valid_drives_a: assert property (!cpu_valid_n |-> addr_data_bus_oe && command_id_bus_oe)
    else $error("valid not driving");
  owner_drives_a: assert property (addr_data_bus_oe |-> !cpu_owns_bus_n)
    else $error("drive not owner");
  oe_pair_a: assert property (addr_data_bus_oe == command_id_bus_oe)
    else $error("enables differ");
  write_walk_a: assert property (
    req_valid && req_ready && !req_is_read |=> !cpu_valid_n && !command_id_bus_out[4]
    && addr_data_bus_out == $past(req_addr) ##1 !cpu_valid_n && command_id_bus_out[4]) else $error("write walk");
  ready_gate_a: assert property (req_valid && req_ready |-> !$past(agent_accept_ready_n))
    else $error("taken while not ready");
  arb_gate_a: assert property (!$past(agent_ownership_request_n) |-> !req_ready)
    else $error("ready during request");
  read_hold_a: assert property (req_valid && req_ready && req_is_read |=> !req_ready [*3])
    else $error("request while read pends");
  cover property (req_valid && req_ready && req_is_read);
  cover property (req_valid && req_ready && !req_is_read);
  cover property ($rose(cpu_owns_bus_n));
endmodule // nsbhp_assertions

// File: bench/nsbhp_agent.sv
// far-end agent model answering reads
`timescale 1ns/100ps
module nsbhp_agent (
  // clock and reset
  input wire clk, rst_n,
  // processor pins
  input wire [31:0] cpu_ad, input wire [4:0] cpu_cmd, input wire cpu_oe, cmd_oe, cpu_valid_n, cpu_owns_bus_n,
  // scenario controls
  input wire [7:0] lat, input wire mute, err,
  // resolved levels
  output wire [31:0] ad, output wire [4:0] cmd, output wire valid_n
);
  reg pend_reg, drv_reg;
  reg [7:0] cnt_reg;
  reg [31:0] ad_last_reg;
  reg [4:0] cmd_last_reg;
  assign ad = cpu_oe ? cpu_ad : drv_reg ? 32'h5A5AC3C3 : ~ad_last_reg;
  assign cmd = cmd_oe ? cpu_cmd : drv_reg ? {2'b10, err, 2'b01} : ~cmd_last_reg;
  assign valid_n = ~drv_reg;
  always @(posedge clk) begin
    ad_last_reg <= ad;
    cmd_last_reg <= cmd;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      drv_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      drv_reg <= 1'b0;
      if (!cpu_valid_n) pend_reg <= !cmd[4];
      if (pend_reg && cpu_owns_bus_n && !mute) cnt_reg <= cnt_reg + 8'h01;
      if (pend_reg && cnt_reg == lat) begin
        drv_reg <= 1'b1;
        pend_reg <= 1'b0;
        cnt_reg <= 8'h00;
      end
    end
  end
endmodule // nsbhp_agent

// File: bench/tb_narrow_sys_bus_handshake_port.sv
// testbench for the narrow bus port
`timescale 1ns/100ps
module tb_narrow_sys_bus_handshake_port;
  reg clk = 0, rst_n = 0, rdy_n = 1, oreq_n = 1, mute = 0, err = 0, rv = 0, rd = 0;
  reg [31:0] ra = 0;
  reg [7:0] lat = 8'h02;
  integer err_count = 0, comparisons = 0, n;
  wire [31:0] ado, adl, rdat;
  wire [4:0] co, cl;
  wire [3:0] up, cb, rid;
  wire aoe, coe, par, avn, vn, own, rdy, rsv, be, eav;
  nsbhp_port #(.TIMEOUT_CYC(16'h0010)) nsbhp_port_i (.clk(clk), .rst_n(rst_n), .addr_data_bus_in(adl),
    .addr_data_bus_out(ado), .addr_data_bus_oe(aoe), .command_id_bus_in(cl), .command_id_bus_out(co),
    .command_id_bus_oe(coe), .command_id_upper_out(up), .unused_check_bits(cb), .unused_command_parity(par),
    .agent_valid_n(avn), .cpu_valid_n(vn), .agent_ownership_request_n(oreq_n), .cpu_owns_bus_n(own),
    .agent_accept_ready_n(rdy_n), .unused_read_ready_n(1'b0), .req_valid(rv), .req_is_read(rd), .req_addr(ra),
    .req_cmd(ra[3:0]), .req_wdata(~ra), .req_wid(ra[7:4]), .req_ready(rdy), .rsp_valid(rsv), .rsp_data(rdat),
    .rsp_id(rid), .ext_addr_valid(eav), .bus_error(be));
  nsbhp_agent nsbhp_agent_i (.clk(clk), .rst_n(rst_n), .cpu_ad(ado), .cpu_cmd(co), .cpu_oe(aoe), .cmd_oe(coe),
    .cpu_valid_n(vn), .cpu_owns_bus_n(own), .lat(lat), .mute(mute), .err(err), .ad(adl), .cmd(cl), .valid_n(avn));
  initial forever #5 clk = ~clk;
  task chk(input [15:0] nm, input [39:0] seen, exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // request held until taken or for at most 41 cycles, returns during address cycle
  task go(input r, input [31:0] a);
    begin
      @(negedge clk);
      rv = 1;
      rd = r;
      ra = a;
      repeat (40) if (!rdy) @(negedge clk);
      @(negedge clk);
      rv = 0;
    end
  endtask
  task t_write;
    begin
      go(0, 32'h80001234);
      chk("wa", ado, 32'h80001234);
      chk("wc", {vn, co}, 6'h04);
      @(negedge clk);
      chk("wd", ado, 32'h7FFFEDCB);
      chk("wi", {vn, co}, 6'h13);
      @(negedge clk);
      chk("wn", vn, 1);
    end
  endtask
  task t_read(input [7:0] l, input e);
    begin
      lat = l;
      err = e;
      go(1, 32'h00000040);
      chk("rp", rdy, 0);
      repeat (2) @(negedge clk);
      chk("ro", {own, aoe}, 2'b10);
      n = 0;
      while (n < 40 && (e ? !be : !rsv)) begin
        @(negedge clk);
        n = n + 1;
      end
      if (e) chk("re", be, 1);
      else chk("rd", {rid, rdat}, 36'h15A5AC3C3);
      repeat (4) @(negedge clk);
      chk("rb", own, 0);
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    chk("tz", {up, cb, par, own, rdy}, 0);
    rdy_n = 0;
    t_read(8'h01, 0);
    t_write;
    oreq_n = 0;
    repeat (3) @(negedge clk);
    chk("ao", {own, aoe, rdy, eav}, 4'b1000);
    oreq_n = 1;
    repeat (4) @(negedge clk);
    t_read(8'h06, 1);
    mute = 1;
    t_read(8'h02, 1);
    test_done;
  end
  initial begin
    #50000;
    err_count = err_count + 1;
    test_done;
  end
endmodule // tb_narrow_sys_bus_handshake_port
bind nsbhp_port nsbhp_assertions nsbhp_assertions_i (.clk, .rst_n, .addr_data_bus_out, .addr_data_bus_oe,
  .command_id_bus_oe, .command_id_bus_out, .command_id_upper_out, .unused_check_bits, .unused_command_parity,
  .cpu_valid_n, .cpu_owns_bus_n, .agent_accept_ready_n, .agent_ownership_request_n, .req_valid, .req_is_read,
  .req_ready, .req_addr);
